// [hw/stack_pkg.sv]
// constants and types shared by the stack instruction engine
package stack_pkg;

   // ****************************************
   // opcodes
   // ****************************************
   localparam logic [15:0] OPC_FLAGS_POP  = 16'h0003;
   localparam logic [15:0] OPC_FLAGS_PUSH = 16'h0002;
   localparam logic [15:0] OPC_RET        = 16'hfffc;
   localparam logic [15:0] OPC_PUSH_I32   = 16'h09ef;
   localparam logic [15:0] OPC_PUSH_S16   = 16'h099f;
   localparam logic [15:0] OPC_PUSH_W16   = 16'h098f;
   localparam logic [15:0] OPC_PUSH_B8X   = 16'h094f;
   localparam logic [11:0] PFX_POP_Q      = 12'h13f;
   localparam logic [11:0] PFX_SIGNED_WORD_POP     = 12'h1ff;
   localparam logic [11:0] PFX_UNSIGNED_WORD_POP     = 12'h1bf;
   localparam logic [11:0] PFX_POP_SB     = 12'h1df;
   localparam logic [11:0] PFX_POP_UB     = 12'h19f;
   localparam logic [7:0]  OPB_MPOP_LO    = 8'h06;
   localparam logic [7:0]  OPB_MPOP_HI    = 8'h07;
   localparam logic [7:0]  OPB_MPUSH_LO   = 8'h04;
   localparam logic [7:0]  OPB_MPUSH_HI   = 8'h05;
   localparam logic [7:0]  OPB_PUSH_Q8    = 8'h0d;
   localparam logic [7:0]  OPB_PUSH_W8    = 8'h0c;
   localparam logic [7:0]  OPB_PUSH_B8    = 8'h0a;
   localparam logic [7:0]  OPB_PUSH_RQ    = 8'h10;
   localparam logic [7:0]  OPB_PUSH_RW    = 8'h16;
   localparam logic [7:0]  OPB_PUSH_RB    = 8'h14;
   localparam logic [3:0]  SP_INDEX       = 4'hf;

   // ****************************************
   // sizes, steps, flags, reset values
   // ****************************************
   localparam logic [2:0]  SIZE_B         = 3'h1;
   localparam logic [2:0]  SIZE_W         = 3'h2;
   localparam logic [2:0]  SIZE_Q         = 3'h4;
   localparam logic [31:0] FLAGS_POP_PRE  = 32'h1;
   localparam logic [31:0] FLAGS_POP_STEP = 32'h2;
   localparam logic [7:0]  FLAGS_PUSH_PAD = 8'h00;
   localparam int          FLAG_ZV_BIT    = 3;
   localparam logic [7:0]  FLAGS_RST      = 8'h00;
   localparam logic [31:0] PC_RST         = 32'h0;
   localparam logic [31:0] SP_RST         = 32'h0;

   typedef enum logic [3:0] {
      OP_BAD    = 4'h0,
      OP_POP    = 4'h1,
      OP_FLAGS_POP  = 4'h2,
      OP_MPOP   = 4'h3,
      OP_PUSH_R = 4'h4,
      OP_PUSH_I = 4'h5,
      OP_FLAGS_PUSH = 4'h6,
      OP_MPUSH  = 4'h7,
      OP_RET    = 4'h8
   } op_t;

   typedef enum logic [1:0] {
      W8  = 2'h0,
      W16 = 2'h1,
      W32 = 2'h2
   } width_t;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'h0,
      ST_GETSP  = 4'h1,
      ST_GETEXT = 4'h2,
      ST_GETSRC = 4'h3,
      ST_PREDEC = 4'h4,
      ST_XFER   = 4'h5,
      ST_WRBACK = 4'h6,
      ST_SCAN   = 4'h7,
      ST_FIN    = 4'h8
   } state_t;

   typedef struct packed {
      op_t        op;
      logic [2:0] n;
      width_t     w;
      logic       sx;
      logic [3:0] rg;
      logic [1:0] ext;
   } decode_t;

endpackage

// [hw/stack_regfile.sv]
// sixteen 32-bit general registers, one write port, registered read
`timescale 1ns/1ps
module stack_regfile
   import stack_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        wr_en,
   input  wire logic [3:0]  wr_addr,
   input  wire logic [31:0] wr_data,
   input  wire logic [3:0]  rd_addr,
   output logic      [31:0] rd_data
);

   logic [31:0] mem [16];

   // no reset on the array so it maps onto plain storage
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 32'h0;
      end else begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule

// [hw/stack_exec.sv]
// stack instruction engine: pops, pushes, multiple forms, flags, return
`timescale 1ns/1ps
module stack_exec
   import stack_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        INSTR_VALID,
   input  wire logic [15:0] INSTR_WORD,
   output logic             INSTR_READY,
   output logic             EXT_REQ,
   input  wire logic        EXT_VALID,
   input  wire logic [15:0] EXT_WORD,
   output logic             MEM_REQ,
   output logic             MEM_WE,
   output logic      [31:0] MEM_ADDR,
   output logic      [7:0]  MEM_WDATA,
   input  wire logic [7:0]  MEM_RDATA,
   input  wire logic        MEM_ACK,
   output logic      [7:0]  FLAGS,
   output logic             PC_LOAD,
   output logic      [31:0] PC_OUT,
   output logic             BUSY,
   output logic             DONE,
   output logic             ILLEGAL
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic decode_t decode(input logic [15:0] iw);
      decode_t d;
      d = '{op: OP_BAD, n: SIZE_Q, w: W32, sx: 1'b0, rg: iw[3:0],
            ext: 2'h0};
      if (iw == OPC_FLAGS_POP) begin
         d.op = OP_FLAGS_POP;
         d.n  = SIZE_B;
      end else if (iw == OPC_FLAGS_PUSH) begin
         d.op = OP_FLAGS_PUSH;
         d.n  = SIZE_W;
         d.w  = W16;
      end else if (iw == OPC_RET) begin
         d.op = OP_RET;
      end else if (iw == OPC_PUSH_I32) begin
         d = '{OP_PUSH_I, SIZE_Q, W32, 1'b1, iw[3:0], 2'h2};
      end else if (iw == OPC_PUSH_S16) begin
         d = '{OP_PUSH_I, SIZE_Q, W16, 1'b1, iw[3:0], 2'h1};
      end else if (iw == OPC_PUSH_W16) begin
         d = '{OP_PUSH_I, SIZE_W, W16, 1'b1, iw[3:0], 2'h1};
      end else if (iw == OPC_PUSH_B8X) begin
         d = '{OP_PUSH_I, SIZE_B, W8, 1'b1, iw[3:0], 2'h1};
      end else if (iw[15:4] == PFX_POP_Q) begin
         d.op = OP_POP;
      end else if (iw[15:4] == PFX_SIGNED_WORD_POP) begin
         d = '{OP_POP, SIZE_W, W16, 1'b1, iw[3:0], 2'h0};
      end else if (iw[15:4] == PFX_UNSIGNED_WORD_POP) begin
         d = '{OP_POP, SIZE_W, W16, 1'b0, iw[3:0], 2'h0};
      end else if (iw[15:4] == PFX_POP_SB) begin
         d = '{OP_POP, SIZE_B, W8, 1'b1, iw[3:0], 2'h0};
      end else if (iw[15:4] == PFX_POP_UB) begin
         d = '{OP_POP, SIZE_B, W8, 1'b0, iw[3:0], 2'h0};
      end else begin
         case (iw[15:8])
            OPB_MPOP_LO, OPB_MPOP_HI:   d.op = OP_MPOP;
            OPB_MPUSH_LO, OPB_MPUSH_HI: d.op = OP_MPUSH;
            OPB_PUSH_Q8: d = '{OP_PUSH_I, SIZE_Q, W8, 1'b1, iw[3:0], 2'h0};
            OPB_PUSH_W8: d = '{OP_PUSH_I, SIZE_W, W8, 1'b1, iw[3:0], 2'h0};
            OPB_PUSH_B8: d = '{OP_PUSH_I, SIZE_B, W8, 1'b1, iw[3:0], 2'h0};
            OPB_PUSH_RQ, OPB_PUSH_RW, OPB_PUSH_RB: begin
               if (iw[3:0] == SP_INDEX) begin
                  d.op = OP_PUSH_R;
                  d.rg = iw[7:4];
                  d.n  = (iw[15:8] == OPB_PUSH_RQ) ? SIZE_Q :
                         (iw[15:8] == OPB_PUSH_RW) ? SIZE_W : SIZE_B;
               end
            end
            default: d.op = OP_BAD;
         endcase
      end
      return d;
   endfunction

   function automatic logic [31:0] extend(input logic [31:0] v,
                                          input width_t w,
                                          input logic sx);
      case (w)
         W8:      return {{24{sx & v[7]}}, v[7:0]};
         W16:     return {{16{sx & v[15]}}, v[15:0]};
         default: return v;
      endcase
   endfunction

   function automatic logic [4:0] align_shift(input logic [2:0] n);
      case (n)
         SIZE_B:  return 5'd24;
         SIZE_W:  return 5'd16;
         default: return 5'd0;
      endcase
   endfunction

   // ****************************************
   // state
   // ****************************************
   state_t      st;
   decode_t     dec;
   decode_t     cur;
   logic [7:0]  mask;
   logic        hi;
   logic [3:0]  idx;
   logic [1:0]  bcnt;
   logic [1:0]  ext_left;
   logic [31:0] data;
   logic [31:0] sp;
   logic [31:0] popval;
   logic [31:0] sp_base;
   logic [31:0] step;
   logic [3:0]  multi_reg;
   logic [3:0]  rd_addr;
   logic [31:0] rd_data;
   logic        wr_en;
   logic [3:0]  wr_addr;
   logic [31:0] wr_data;
   logic        is_push;
   logic        last_byte;
   logic        accept;

   assign dec         = decode(INSTR_WORD);
   assign accept      = (st == ST_IDLE) && INSTR_VALID;
   assign INSTR_READY = (st == ST_IDLE);
   assign BUSY        = (st != ST_IDLE);
   assign EXT_REQ     = (st == ST_GETEXT);
   assign is_push     = (cur.op == OP_PUSH_R) || (cur.op == OP_PUSH_I) ||
                        (cur.op == OP_FLAGS_PUSH) || (cur.op == OP_MPUSH);
   assign last_byte   = ({1'b0, bcnt} == cur.n - 3'h1);
   // push object mask is mirrored so one walk order serves both
   assign multi_reg   = (cur.op == OP_MPUSH) ? {hi, ~idx[2:0]} :
                                               {hi, idx[2:0]};
   assign popval      = extend(data, cur.w, cur.sx);

   // ****************************************
   // memory port
   // ****************************************
   assign MEM_REQ   = (st == ST_XFER);
   assign MEM_WE    = (st == ST_XFER) && is_push;
   // flags pop reads the byte above the pointer
   assign MEM_ADDR  = sp + ((cur.op == OP_FLAGS_POP) ? FLAGS_POP_PRE :
                                                  {30'h0, bcnt});
   assign MEM_WDATA = data[31:24];

   // ****************************************
   // register file port
   // ****************************************
   always_comb begin
      rd_addr = SP_INDEX;
      if (st == ST_GETSP) begin
         rd_addr = cur.rg;
      end else if (st == ST_SCAN) begin
         rd_addr = multi_reg;
      end
      wr_en   = 1'b0;
      wr_addr = SP_INDEX;
      wr_data = sp;
      if (st == ST_WRBACK && cur.op == OP_POP) begin
         wr_en   = 1'b1;
         wr_addr = cur.rg;
         wr_data = popval;
      end else if (st == ST_WRBACK && cur.op == OP_MPOP) begin
         wr_en   = 1'b1;
         wr_addr = multi_reg;
         wr_data = data;
      end else if (st == ST_FIN) begin
         wr_en = 1'b1;
      end
   end

   stack_regfile u_regs (
      .clk     (CLK),
      .rst_n   (RST_N),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .rd_addr (rd_addr),
      .rd_data (rd_data)
   );

   // ****************************************
   // sequencing
   // ****************************************
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st       <= ST_IDLE;
         cur      <= '{OP_BAD, SIZE_Q, W32, 1'b0, 4'h0, 2'h0};
         mask     <= 8'h00;
         hi       <= 1'b0;
         idx      <= 4'h0;
         bcnt     <= 2'h0;
         ext_left <= 2'h0;
      end else begin
         case (st)
            ST_IDLE: begin
               if (accept && dec.op != OP_BAD) begin
                  cur      <= dec;
                  mask     <= INSTR_WORD[7:0];
                  hi       <= INSTR_WORD[8];
                  idx      <= 4'h0;
                  bcnt     <= 2'h0;
                  ext_left <= dec.ext;
                  st       <= ST_GETSP;
               end
            end
            ST_GETSP: begin
               if (ext_left != 2'h0) begin
                  st <= ST_GETEXT;
               end else begin
                  case (cur.op)
                     OP_PUSH_R:          st <= ST_GETSRC;
                     OP_PUSH_I, OP_FLAGS_PUSH: st <= ST_PREDEC;
                     OP_MPOP, OP_MPUSH:  st <= ST_SCAN;
                     default:            st <= ST_XFER;
                  endcase
               end
            end
            ST_GETEXT: begin
               if (EXT_VALID) begin
                  ext_left <= ext_left - 2'h1;
                  if (ext_left == 2'h1) begin
                     st <= ST_PREDEC;
                  end
               end
            end
            ST_GETSRC: st <= ST_PREDEC;
            ST_PREDEC: st <= ST_XFER;
            ST_XFER: begin
               if (MEM_ACK) begin
                  bcnt <= bcnt + 2'h1;
                  if (last_byte) begin
                     bcnt <= 2'h0;
                     if (!is_push) begin
                        st <= ST_WRBACK;
                     end else if (cur.op == OP_MPUSH) begin
                        idx <= idx + 4'h1;
                        st  <= ST_SCAN;
                     end else begin
                        st <= ST_FIN;
                     end
                  end
               end
            end
            ST_WRBACK: begin
               if (cur.op == OP_MPOP) begin
                  idx <= idx + 4'h1;
                  st  <= ST_SCAN;
               end else begin
                  st <= ST_FIN;
               end
            end
            ST_SCAN: begin
               if (idx[3]) begin
                  st <= ST_FIN;
               end else if (mask[idx[2:0]]) begin
                  st <= (cur.op == OP_MPUSH) ? ST_GETSRC : ST_XFER;
               end else begin
                  idx <= idx + 4'h1;
               end
            end
            ST_FIN:  st <= ST_IDLE;
            default: st <= ST_IDLE;
         endcase
      end
   end

   // ****************************************
   // data shifter
   // ****************************************
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         data <= 32'h0;
      end else if (accept) begin
         data <= {24'h0, INSTR_WORD[7:0]};
      end else if (st == ST_GETSP && cur.op == OP_FLAGS_PUSH) begin
         data <= {16'h0, FLAGS_PUSH_PAD, FLAGS};
      end else if (st == ST_GETEXT && EXT_VALID) begin
         data <= {data[15:0], EXT_WORD};
      end else if (st == ST_GETSRC) begin
         data <= rd_data;
      end else if (st == ST_PREDEC) begin
         // truncation falls out of the shift, top bytes go first
         data <= extend(data, cur.w, cur.sx) << align_shift(cur.n);
      end else if (st == ST_XFER && MEM_ACK) begin
         data <= is_push ? {data[23:0], 8'h00} :
                           {data[23:0], MEM_RDATA};
      end
   end

   // ****************************************
   // stack pointer shadow, written back in the final cycle
   // ****************************************
   assign step    = (cur.op == OP_FLAGS_POP) ? FLAGS_POP_STEP : {29'h0, cur.n};
   assign sp_base = (wr_en && wr_addr == SP_INDEX) ? wr_data : sp;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         sp <= SP_RST;
      end else if (st == ST_GETSP) begin
         sp <= rd_data;
      end else if (st == ST_PREDEC) begin
         sp <= sp - {29'h0, cur.n};
      end else if (st == ST_WRBACK) begin
         sp <= sp_base + step;
      end
   end

   // ****************************************
   // flags, program counter, status pulses
   // ****************************************
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         FLAGS <= FLAGS_RST;
      end else if (st == ST_WRBACK && cur.op == OP_FLAGS_POP) begin
         FLAGS <= data[7:0];
      end else if (st == ST_WRBACK && cur.op == OP_MPOP) begin
         FLAGS[FLAG_ZV_BIT] <= (data == 32'h0);
      end else if (st == ST_WRBACK && cur.op == OP_POP) begin
         FLAGS[FLAG_ZV_BIT] <= (popval == 32'h0);
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         PC_OUT  <= PC_RST;
         PC_LOAD <= 1'b0;
         DONE    <= 1'b0;
         ILLEGAL <= 1'b0;
      end else begin
         PC_LOAD <= (st == ST_WRBACK && cur.op == OP_RET);
         if (st == ST_WRBACK && cur.op == OP_RET) begin
            PC_OUT <= data;
         end
         DONE    <= (st == ST_FIN);
         ILLEGAL <= accept && (dec.op == OP_BAD);
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   sequence s_wrback(op_t o);
      st == ST_WRBACK && cur.op == o;
   endsequence

   chk_pop_decode: assert property (
      accept && INSTR_WORD[15:4] == PFX_SIGNED_WORD_POP |=>
         cur.op == OP_POP && cur.n == SIZE_W && cur.sx)
      else $error("signed word pop decoded wrongly");

   chk_flags_pop_sp: assert property (
      s_wrback(OP_FLAGS_POP) |=> sp == $past(sp) + 32'h2)
      else $error("flags pop did not add two to pointer");

   chk_flags_pop_all: assert property (
      s_wrback(OP_FLAGS_POP) |=> FLAGS == $past(data[7:0]))
      else $error("flags pop did not load whole byte");

   chk_multi_pop_sp: assert property (
      s_wrback(OP_MPOP) && multi_reg != SP_INDEX |=>
         sp == $past(sp) + 32'h4)
      else $error("multi pop pointer step wrong");

   chk_multi_pop_zero: assert property (
      s_wrback(OP_MPOP) |=>
         FLAGS[FLAG_ZV_BIT] == ($past(data) == 32'h0) &&
         FLAGS[7:4] == $past(FLAGS[7:4]) &&
         FLAGS[2:0] == $past(FLAGS[2:0]))
      else $error("multi pop flag update wrong");

   chk_push_predec: assert property (
      st == ST_PREDEC |=> sp == $past(sp) - {29'h0, cur.n} && st == ST_XFER)
      else $error("push pre-decrement wrong");

   chk_flags_push_pad: assert property (
      MEM_WE && cur.op == OP_FLAGS_PUSH && bcnt == 2'h0 |->
         MEM_WDATA == FLAGS_PUSH_PAD && MEM_ADDR == sp)
      else $error("flags push pad byte wrong");

   chk_push_flags_keep: assert property (
      st != ST_IDLE && (is_push || cur.op == OP_RET) |=> $stable(FLAGS))
      else $error("flags changed by push or return");

   chk_ret_pc: assert property (
      s_wrback(OP_RET) |=> PC_LOAD && PC_OUT == $past(data) &&
         sp == $past(sp) + 32'h4)
      else $error("return did not load pc");

   chk_push_addr: assert property (
      MEM_REQ && is_push && cur.op != OP_FLAGS_PUSH |->
         MEM_ADDR == sp + {30'h0, bcnt})
      else $error("push byte address out of order");

endmodule

// [dv/stack_mem_model.sv]
// byte-wide stack memory answering the engine's request handshake
`timescale 1ns/1ps
module stack_mem_model (
   input  wire logic        clk,
   input  wire logic        req,
   input  wire logic        we,
   input  wire logic [31:0] addr,
   input  wire logic [7:0]  wdata,
   input  wire logic [3:0]  lag,
   input  wire logic        boot,
   input  wire logic [31:0] boot_word,
   output logic             ack,
   output logic      [7:0]  rdata
);
   // ****************************************
   // storage and answer
   // ****************************************
   logic [7:0] mem [0:4095];
   logic [3:0] wait_cnt = 4'h0;
   logic [1:0] boot_idx = 2'h0;
   logic [7:0] last     = 8'h00;

   assign ack = req && (wait_cnt == lag);

   // a released data line shows the inverse of the last byte, never a copy
   always_comb begin
      if (!ack || we)
         rdata = ~last;
      else if (boot)
         rdata = boot_word[31 - 8 * int'(boot_idx) -: 8];
      else
         rdata = mem[addr[11:0]];
   end

   // boot mode serves the first pointer load while the address is unknown
   always @(posedge clk) begin
      if (req && ack) begin
         wait_cnt <= 4'h0;
         last     <= we ? wdata : rdata;
         if (we)
            mem[addr[11:0]] <= wdata;
         else if (boot)
            boot_idx <= boot_idx + 2'h1;
      end else if (req) begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule

// [dv/stack_push_pop_execution_bench.sv]
// self-checking bench for the stack instruction engine
`timescale 1ns/1ps
module stack_push_pop_execution_bench;
   import stack_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic        ext_valid = 1'b0;
   logic [15:0] ext_word = 16'h0000;
   logic        instr_ready, ext_req, mem_req, mem_we, mem_ack;
   logic        pc_load, busy, done, ill, boot, took;
   logic [31:0] mem_addr, pc_out, pc_seen, sp;
   logic [7:0]  mem_wdata, mem_rdata, flags;
   logic [3:0]  lag = 4'h0;
   logic [15:0] ext_q [$];
   int          mismatches = 0;
   int          check_count = 0;

   stack_exec dut_u (.CLK(clk), .RST_N(rst_n), .INSTR_VALID(instr_valid),
      .INSTR_WORD(instr_word), .INSTR_READY(instr_ready), .EXT_REQ(ext_req),
      .EXT_VALID(ext_valid), .EXT_WORD(ext_word), .MEM_REQ(mem_req),
      .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
      .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack), .FLAGS(flags),
      .PC_LOAD(pc_load), .PC_OUT(pc_out), .BUSY(busy), .DONE(done),
      .ILLEGAL(ill));
   stack_mem_model mem_u (.clk(clk), .req(mem_req), .we(mem_we),
      .addr(mem_addr), .wdata(mem_wdata), .lag(lag), .boot(boot),
      .boot_word(32'h000007fc), .ack(mem_ack), .rdata(mem_rdata));

   // ****************************************
   // clock, drivers and helpers
   // ****************************************
   initial begin
      forever #2 clk = ~clk;
   end

   // ext_req is stable from the falling edge, so the take is judged there
   always @(negedge clk) begin
      if (took)
         void'(ext_q.pop_front());
      ext_valid = ext_q.size() > 0;
      ext_word  = ext_valid ? ext_q[0] : ~ext_word;
      took      = ext_req && ext_valid;
      if (pc_load === 1'b1)
         pc_seen = pc_out;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      if (mismatches == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic put32(input int a, input logic [31:0] v);
      for (int i = 0; i < 4; i++)
         mem_u.mem[a + i] = v[31 - 8 * i -: 8];
   endtask

   function automatic logic [31:0] get(input int a, input int n);
      logic [31:0] v;
      v = 32'h0;
      for (int i = 0; i < n; i++)
         v = {v[23:0], mem_u.mem[a + i]};
      return v;
   endfunction

   // offers one word while idle and waits, bounded, for its completion
   task automatic issue(input logic [15:0] w);
      int n;
      n = 0;
      @(negedge clk);
      while (instr_ready !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      instr_valid = 1'b1;
      instr_word  = w;
      @(negedge clk);
      instr_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && ill !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n >= 200)
         mismatches++;
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_pops();
      logic [11:0] pfx [5] = '{PFX_POP_Q, PFX_SIGNED_WORD_POP, PFX_UNSIGNED_WORD_POP,
                               PFX_POP_SB, PFX_POP_UB};
      int          stp [5] = '{4, 2, 2, 1, 1};
      logic [31:0] x   [5] = '{32'h86421122, 32'hffff8642, 32'h00008642,
                               32'hffffff86, 32'h00000086};
      lag = 4'h2;
      for (int i = 0; i < 5; i++) begin
         put32(sp, 32'h86421122);
         issue({pfx[i], 4'h6});
         sp = sp + stp[i] - 4;
         issue({OPB_PUSH_RQ, 4'h6, SP_INDEX});
         check(get(sp, 4), x[i]);
      end
   endtask

   task automatic t_flags();
      logic [7:0] v [2] = '{8'h4e, 8'hb1};
      lag = 4'h0;
      for (int i = 0; i < 2; i++) begin
         put32(sp, {8'h5a, v[i], 16'h0});
         issue(OPC_FLAGS_POP);
         check(flags, v[i]);
         issue(OPC_FLAGS_PUSH);
         check(get(sp, 2), {16'h0, 8'h00, v[i]});
         check(flags, v[i]);
      end
   endtask

   task automatic t_multi();
      logic [31:0] w [5] = '{32'h1234, 32'h55678, 32'h69abc, 32'h0, 32'hd4321};
      lag = 4'h3;
      for (int i = 0; i < 5; i++)
         put32(sp + 4 * i, w[i]);
      issue({OPB_MPOP_LO, 8'he1});
      check(flags, 8'hb9);
      issue({OPB_MPOP_HI, 8'h20});
      check(flags, 8'hb1);
      for (int i = 0; i < 20; i++)
         mem_u.mem[sp + i] = 8'h5a;
      issue({OPB_MPUSH_HI, 8'h04});
      issue({OPB_MPUSH_LO, 8'h87});
      for (int i = 0; i < 5; i++)
         check(get(sp + 4 * i, 4), w[i]);
      check(flags, 8'hb1);
   endtask

   // immediate and register pushes; R5 holds 0005_5678 by now
   task automatic t_push();
      logic [15:0] op [11] = '{16'h0d42, 16'h0df0, 16'h0cf0, 16'h0a80,
         OPC_PUSH_I32, OPC_PUSH_S16, OPC_PUSH_W16, OPC_PUSH_B8X,
         16'h105f, 16'h165f, 16'h145f};
      int          n  [11] = '{4, 4, 2, 1, 4, 4, 2, 1, 4, 2, 1};
      int          nx [11] = '{0, 0, 0, 0, 2, 1, 1, 1, 0, 0, 0};
      logic [31:0] e  [11] = '{0, 0, 0, 0, 32'h12345678, 32'h8001,
         32'habcd, 32'h3377, 0, 0, 0};
      logic [31:0] x  [11] = '{32'h42, 32'hfffffff0, 32'hfff0, 32'h80,
         32'h12345678, 32'hffff8001, 32'habcd, 32'h77, 32'h55678,
         32'h5678, 32'h78};
      lag = 4'h1;
      for (int i = 0; i < 11; i++) begin
         if (nx[i] == 2)
            ext_q.push_back(e[i][31:16]);
         if (nx[i] > 0)
            ext_q.push_back(e[i][15:0]);
         issue(op[i]);
         sp = sp - n[i];
         check(get(sp, n[i]), x[i]);
         check(flags, 8'hb1);
      end
   endtask

   task automatic t_ret();
      put32(sp, 32'h00000454);
      issue(OPC_RET);
      check(pc_seen, 32'h00000454);
      sp = sp + 2;
      issue(OPC_FLAGS_PUSH);
      check(get(sp, 2), 32'h000000b1);
      issue(16'h0000);
      check(ill, 1'b1);
      check(busy, 1'b0);
      check(flags, 8'hb1);
   endtask

   // a short run; the limit is far beyond the several hundred cycles needed
   initial begin
      #80000;
      mismatches++;
      close_out();
   end

   initial begin
      boot = 1'b1;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      issue({PFX_POP_Q, SP_INDEX});
      boot = 1'b0;
      sp = 32'h00000800;
      t_pops();
      t_flags();
      t_multi();
      t_push();
      t_ret();
      close_out();
   end
endmodule
